// ==== bench/clock_seq_sva.sv ====
// Assertion checker for the clock driver and reset sequencer ports.
module clock_seq_sva (
   input wire logic                       mclk,
   input wire logic                       reset_n,
   input wire logic                       ce,
   input wire logic                       ref_clk_in,
   input wire logic                       loop_run_enable_in,
   input wire logic                       reset_req_in,
   input wire logic                       lock_detect_in,
   input wire clock_seq_pkg::clock_outs_t clock_outs,
   input wire logic                       feedback_out,
   input wire logic                       rst_lock_out,
   input wire logic                       rst_lock_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0]  age_reg;
   logic [12:0] since_reg;
   wire         calm = age_reg == 5'h1f && loop_run_enable_in && ce;
   always_ff @(posedge mclk) begin
      age_reg <= !reset_n ? 5'h00 : age_reg + {4'h0, age_reg != 5'h1f};
      since_reg <= (!reset_n || !reset_req_in || !lock_detect_in || !loop_run_enable_in) ? 13'h0000
                   : since_reg + {12'h000, since_reg != 13'h1fff};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   inv_base_a: assert property (age_reg == 5'h1f |-> clock_outs.inverted_base_clock_out != clock_outs.base_clock_outs[0])
      else $error("inverted clock is not the inverse of base");
   dbl_base_a: assert property (calm && $rose(clock_outs.base_clock_outs[0]) |-> $rose(clock_outs.double_rate_clock_out))
      else $error("double rate clock missed a base rise");
   enable_slot_a: assert property (calm && $rose(clock_outs.base_clock_outs[0]) |=>
      clock_outs.half_rate_enable_out && !clock_outs.double_rate_clock_out ##1 !clock_outs.half_rate_enable_out)
      else $error("half rate enable misplaced");
   tri_only_a: assert property (rst_lock_out == 1'b0)
      else $error("reset pin driven high");
   req_hold_a: assert property (!reset_req_in [*3] |=> rst_lock_oe)
      else $error("reset not held during request");
   lock_wait_a: assert property ((reset_req_in && !lock_detect_in && loop_run_enable_in) [*3] |=> rst_lock_oe)
      else $error("reset not held without lock");
   rel_early_a: assert property ($fell(rst_lock_oe) |-> since_reg >= 13'hfe0)
      else $error("reset released too early");
   rel_late_a: assert property (since_reg == 13'h100e |-> !rst_lock_oe)
      else $error("reset released too late");
   fb_half_a: assert property (calm |-> $changed(feedback_out) == $rose(clock_outs.base_clock_outs[0]))
      else $error("feedback does not toggle on base rises");
   ref_align_a: assert property (calm && $rose(ref_clk_in) |-> ##3 $rose(clock_outs.base_clock_outs[0]))
      else $error("base rise not aligned to reference rise");
   cover property ($fell(rst_lock_oe));
   cover property ($rose(rst_lock_oe) && reset_req_in);
   cover property (!loop_run_enable_in && clock_outs.half_rate_enable_out && ref_clk_in);
   cover property ($rose(feedback_out));
endmodule : clock_seq_sva

bind clock_driver_reset_lock_seq clock_seq_sva i_clock_seq_sva (.mclk(mclk), .reset_n(reset_n), .ce(ce),
   .ref_clk_in(ref_clk_in), .loop_run_enable_in(loop_run_enable_in), .reset_req_in(reset_req_in),
   .lock_detect_in(lock_detect_in), .clock_outs(clock_outs), .feedback_out(feedback_out),
   .rst_lock_out(rst_lock_out), .rst_lock_oe(rst_lock_oe));

// ==== bench/proc_model.sv ====
// Processor-side model: reset pin with pull-up and clock edges seen while in reset.
module proc_model (
   input  wire logic double_clk,
   input  wire logic rst_lock_out,
   input  wire logic rst_lock_oe,
   output logic      proc_reset_n,
   output int        edges_in_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   assign proc_reset_n = rst_lock_oe ? rst_lock_out : 1'b1;
   initial edges_in_reset = 0;
   always @(posedge double_clk) begin
      if (!proc_reset_n) begin
         edges_in_reset++;
      end
   end
endmodule : proc_model

// ==== bench/test_clock_driver_reset_lock_seq.sv ====
// Self-checking bench for the clock driver and reset sequencer.
module test_clock_driver_reset_lock_seq;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic req; logic lock; int cycles; logic exp_oe;} row_t;
   logic mclk = 1'b0, reset_n = 1'b0, ref_clk_in = 1'b0, ref_run = 1'b1, ref_hold = 1'b0;
   logic loop_run_enable_in = 1'b1, reset_req_in = 1'b1, lock_detect_in = 1'b0, ce = 1'b1;
   logic [2:0] ref_cnt = 3'h0;
   clock_seq_pkg::clock_outs_t clock_outs;
   logic feedback_out, rst_lock_out, rst_lock_oe, proc_reset_n;
   int edges_in_reset, e0, n_errors = 0, n_compared = 0;
   row_t rows [7] = '{'{1, 0, 40, 1}, '{1, 1, 4200, 0}, '{0, 1, 20, 1}, '{1, 1, 4050, 1},
                      '{1, 1, 80, 0}, '{1, 0, 10, 1}, '{1, 1, 4200, 0}};
   clock_driver_reset_lock_seq i_clock_driver_reset_lock_seq (.mclk(mclk), .reset_n(reset_n), .ce(ce),
      .ref_clk_in(ref_clk_in), .loop_run_enable_in(loop_run_enable_in), .reset_req_in(reset_req_in),
      .lock_detect_in(lock_detect_in), .clock_outs(clock_outs), .feedback_out(feedback_out),
      .rst_lock_out(rst_lock_out), .rst_lock_oe(rst_lock_oe));
   proc_model i_proc_model (.double_clk(clock_outs.double_rate_clock_out), .rst_lock_out(rst_lock_out),
      .rst_lock_oe(rst_lock_oe),
      .proc_reset_n(proc_reset_n), .edges_in_reset(edges_in_reset));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("compared=%0d errors=%0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   initial begin
      forever #25 mclk = ~mclk;
   end
   // Reference runs at half the base rate.
   always @(posedge mclk) begin
      ref_cnt <= ref_cnt + 3'h1;
      ref_clk_in <= ref_run ? ref_cnt[2] : ref_hold;
   end
   initial begin
      #1500000;
      n_errors++;
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge mclk);
      #1;
      check({clock_outs, rst_lock_oe}, 8'h01);
      @(posedge mclk);
      reset_n <= 1'b1;
      foreach (rows[i]) begin
         @(posedge mclk);
         reset_req_in <= rows[i].req;
         lock_detect_in <= rows[i].lock;
         repeat (rows[i].cycles) @(posedge mclk);
         #1;
         check(rst_lock_oe, rows[i].exp_oe);
         check(proc_reset_n, !rows[i].exp_oe);
      end
      @(posedge mclk);
      reset_req_in <= 1'b0;
      @(posedge mclk);
      reset_req_in <= 1'b1;
      e0 = edges_in_reset;
      repeat (40) @(posedge mclk);
      #1;
      check(rst_lock_oe, 1'b1);
      check(edges_in_reset > e0 + 15, 1'b1);
      repeat (4200) @(posedge mclk);
      #1;
      check(rst_lock_oe, 1'b0);
      @(posedge mclk);
      loop_run_enable_in <= 1'b0;
      ref_run <= 1'b0;
      ref_hold <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      check({clock_outs, feedback_out}, 8'h7b);
      @(posedge mclk);
      ref_hold <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      check({clock_outs, feedback_out}, 8'h06);
      @(posedge mclk);
      ce <= 1'b0;
      ref_hold <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      check({clock_outs, feedback_out}, 8'h06);
      @(posedge mclk);
      ce <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      check({clock_outs, feedback_out}, 8'h7b);
      print_verdict();
   end
endmodule : test_clock_driver_reset_lock_seq

// ==== design/clock_driver_reset_lock_seq.sv ====
// Clock output generation and processor reset/lock sequencer.

// What this block does
// [R1] Double-rate clock runs at twice base rate.
// [R2] Base divided by two as feedback.
// [R3] One extra base clock, inverted.
// [R4] Half-rate enable, offset from double-rate clock.
// [R5] Run enable low gives static test mode.
// [R6] Reset output driven low until lock.
// [R7] Hold low 1024 base cycles after lock.
// [R8] Request low at power-up holds output low.
// [R9] Request low pulse lasts at least 10ns.
// [R10] Request while locked: low, then 1024 cycles.
// [R11] Clocks keep running while reset held.
// [R12] Release to high impedance, never drive high.
// [R13] Reference from 5 MHz to quarter-max.
// [R14] Release 1016 to 1024 cycles after rise.
// [R15] Output rising edges align to reference rise.
// [R16] Counter restarts on request or lock loss.
module clock_driver_reset_lock_seq (
   input  wire logic                       mclk,
   input  wire logic                       reset_n,
   input  wire logic                       ce,
   input  wire logic                       ref_clk_in,
   input  wire logic                       loop_run_enable_in,
   input  wire logic                       reset_req_in,
   input  wire logic                       lock_detect_in,
   output clock_seq_pkg::clock_outs_t      clock_outs,
   output logic                            feedback_out,
   output logic                            rst_lock_out,
   output logic                            rst_lock_oe
);

   typedef struct packed {
      logic [clock_seq_pkg::PHASE_W-1:0] phase;
      logic                              ref_prev;
      clock_seq_pkg::seq_state_t         seq;
      logic [clock_seq_pkg::CNT_W-1:0]   cnt;
      clock_seq_pkg::clock_outs_t        outs;
      logic                              feedback;
      logic                              rst_oe;
   } core_state_t;

   core_state_t             s_reg;
   core_state_t             s_next;
   clock_seq_pkg::pin_ins_t pins_raw;
   clock_seq_pkg::pin_ins_t pins;
   logic                    ref_rise;
   logic                    base_edge;
   logic                    locked;

   assign pins_raw = '{ref_clk:         ref_clk_in,
                       loop_run_enable: loop_run_enable_in,
                       reset_req:       reset_req_in,
                       lock_detect:     lock_detect_in};

   pin_sync #(
      .W   (clock_seq_pkg::PIN_W),
      .RST (clock_seq_pkg::PIN_RESET)
   ) u_pin_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .ce      (ce),
      .d       (pins_raw),
      .q       (pins)
   );

   always_comb begin
      s_next          = s_reg;
      s_next.ref_prev = pins.ref_clk;
      ref_rise        = pins.ref_clk & ~s_reg.ref_prev;
      if (pins.loop_run_enable) begin
         // [R15] Reference aligns phase.
         if (ref_rise) begin
            s_next.phase = clock_seq_pkg::PHASE_RESET;
         end else begin
            s_next.phase = s_reg.phase + 3'h1;
         end
         base_edge = (s_next.phase[1:0] == clock_seq_pkg::BASE_RISE_LOW);
         locked    = pins.lock_detect;
         // [R1] Double-rate output.
         s_next.outs.double_rate_clock_out   = ~s_next.phase[0];
         s_next.outs.base_clock_outs         = {3{~s_next.phase[1]}};
         // [R3] Inverted base output.
         s_next.outs.inverted_base_clock_out = s_next.phase[1];
         // [R4] Half-rate enable.
         s_next.outs.half_rate_enable_out    = (s_next.phase[1:0] == clock_seq_pkg::ENABLE_PHASE);
         // [R2] Base divided by two.
         s_next.feedback = ~s_next.phase[2];
      end else begin
         // [R5] Static test mode.
         s_next.phase    = s_reg.phase;
         base_edge       = ref_rise;
         locked          = 1'b1;
         s_next.outs     = '{double_rate_clock_out:   pins.ref_clk,
                             base_clock_outs:         {3{pins.ref_clk}},
                             inverted_base_clock_out: ~pins.ref_clk,
                             half_rate_enable_out:    1'b1};
         s_next.feedback = pins.ref_clk;
      end

      // [R8] Request low holds.
      if (!pins.reset_req) begin
         // [R10] Request restarts hold.
         s_next.seq = clock_seq_pkg::SEQ_HOLD_REQ;
         s_next.cnt = clock_seq_pkg::CNT_RESET;
      end else if (!locked) begin
         // [R16] Lock loss restarts.
         s_next.seq = clock_seq_pkg::SEQ_WAIT_LOCK;
         s_next.cnt = clock_seq_pkg::CNT_RESET;
      end else begin
         case (s_reg.seq)
            clock_seq_pkg::SEQ_WAIT_LOCK,
            clock_seq_pkg::SEQ_HOLD_REQ: begin
               s_next.seq = clock_seq_pkg::SEQ_COUNT;
               s_next.cnt = clock_seq_pkg::CNT_RESET;
            end
            clock_seq_pkg::SEQ_COUNT: begin
               // [R7] Count base cycles.
               if (base_edge) begin
                  // [R14] Release after last.
                  if (s_reg.cnt == clock_seq_pkg::CNT_LAST) begin
                     s_next.seq = clock_seq_pkg::SEQ_RELEASED;
                  end else begin
                     s_next.cnt = s_reg.cnt + 10'h001;
                  end
               end
            end
            clock_seq_pkg::SEQ_RELEASED: begin
               s_next.seq = clock_seq_pkg::SEQ_RELEASED;
            end
            default: begin
               s_next.seq = clock_seq_pkg::SEQ_WAIT_LOCK;
            end
         endcase
      end
      // [R6] Drive low until released.
      s_next.rst_oe = (s_next.seq != clock_seq_pkg::SEQ_RELEASED);
   end

   // [R11] Clocks run during reset.
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_reg <= '{phase:    clock_seq_pkg::PHASE_RESET,
                    ref_prev: 1'b0,
                    seq:      clock_seq_pkg::SEQ_WAIT_LOCK,
                    cnt:      clock_seq_pkg::CNT_RESET,
                    outs:     '0,
                    feedback: 1'b0,
                    rst_oe:   1'b1};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign clock_outs   = s_reg.outs;
   assign feedback_out = s_reg.feedback;
   // [R12] Open drain, only low.
   assign rst_lock_out = 1'b0;
   assign rst_lock_oe  = s_reg.rst_oe;

endmodule : clock_driver_reset_lock_seq

// ==== design/clock_seq_pkg.sv ====
// Shared constants and types for the clock driver and reset sequencer.
package clock_seq_pkg;

   localparam int unsigned            PHASE_W        = 3;
   localparam logic [PHASE_W-1:0]     PHASE_RESET    = 3'h0;
   localparam logic [1:0]             BASE_RISE_LOW  = 2'h0;
   localparam logic [1:0]             ENABLE_PHASE   = 2'h1;
   localparam int unsigned            RELEASE_CYCLES = 1024;
   localparam int unsigned            CNT_W          = 10;
   localparam logic [CNT_W-1:0]       CNT_RESET      = 10'h000;
   localparam logic [CNT_W-1:0]       CNT_LAST       = CNT_W'(RELEASE_CYCLES - 1);
   localparam int unsigned            PIN_W          = 4;
   localparam logic [PIN_W-1:0]       PIN_RESET      = 4'h0;

   typedef enum {
      SEQ_WAIT_LOCK,
      SEQ_HOLD_REQ,
      SEQ_COUNT,
      SEQ_RELEASED
   } seq_state_t;

   typedef struct packed {
      logic       double_rate_clock_out;
      logic [2:0] base_clock_outs;
      logic       inverted_base_clock_out;
      logic       half_rate_enable_out;
   } clock_outs_t;

   typedef struct packed {
      logic ref_clk;
      logic loop_run_enable;
      logic reset_req;
      logic lock_detect;
   } pin_ins_t;

endpackage : clock_seq_pkg

// ==== design/pin_sync.sv ====
// Two-stage synchroniser for a group of pin inputs.
module pin_sync #(
   parameter int unsigned       W   = 4,
   parameter logic [W-1:0]      RST = '0
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_state_t;

   sync_state_t s_reg;
   sync_state_t s_next;

   always_comb begin
      s_next        = s_reg;
      s_next.first  = d;
      s_next.second = s_reg.first;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_reg <= '{first: RST, second: RST};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.second;

endmodule : pin_sync
